// *** logic/pvsir_regs.v ***
// APB register bank: strap status, expanded control, event flags, cable diagnostic.
// Assumes analog diagnostic engine and event sources on clk_sys; straps come from pins.
//
// Functional notes
// - Strap status bits 15:13 read latched station address, 000 or 011.
// - Only station addresses zero and three supported; others latch as zero.
// - Strap status bit 1 reads one when reduced interface mode strapped.
// - Expanded control bit 11 disables energy-detect powerdown; resets to one.
// - Event register bits 15:8 are read-write enables resetting to zero.
// - Order high to low: jabber, rx error, page, pdf, lp ack, down, rf, up.
// - Writing start bit begins diagnostic; bit held until completion then cleared.
// - Result bits 14:13: normal, open, short, failed; reset 00.
// - Bit 12 reads one when cable shorter than ten meters; reset zero.
//
// Local design decision: the APB interface to the registers.
`include "pvsir_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pvsir_regs #(
  parameter NUM_EVENTS = 8,
  parameter DIST_W = 9
) (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] strap_station_address,
  input wire strap_rmii,
  input wire [NUM_EVENTS-1:0] event_pulse,
  input wire diag_done,
  input wire [1:0] diag_result,
  input wire diag_short_cable,
  input wire [DIST_W-1:0] diag_distance,
  output reg diag_start,
  output reg energy_detect_powerdown,
  output reg irq
);

  // Pins pass two flip-flops before use
  reg [3:0] strap_meta_reg;
  reg [3:0] strap_sync_reg;
  reg strap_taken_reg;
  reg [2:0] station_reg;
  reg rmii_reg;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_meta_reg <= 4'h0;
      strap_sync_reg <= 4'h0;
    end else begin
      strap_meta_reg <= {strap_station_address, strap_rmii};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Straps caught once after release, when the synchroniser has settled
  reg [1:0] strap_wait_reg;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_wait_reg <= 2'h0;
      strap_taken_reg <= 1'b0;
      station_reg <= 3'h0;
      rmii_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      if (strap_wait_reg == `PVSIR_STRAP_WAIT) begin
        strap_taken_reg <= 1'b1;
        rmii_reg <= strap_sync_reg[0];
        // Unsupported addresses fall back to zero
        if (strap_sync_reg[3:1] == `PVSIR_STRAP_ADDR_THREE)
          station_reg <= `PVSIR_STRAP_ADDR_THREE;
        else
          station_reg <= `PVSIR_STRAP_ADDR_ZERO;
      end
    end
  end

  wire access_w = psel && penable && pready;
  wire wr_w = access_w && pwrite;
  wire rd_w = access_w && !pwrite;
  wire hit_strap = paddr == `PVSIR_ADDR_STRAP;
  wire hit_expctl = paddr == `PVSIR_ADDR_EXPCTL;
  wire hit_event = paddr == `PVSIR_ADDR_EVENT;
  wire hit_diag = paddr == `PVSIR_ADDR_DIAG;
  wire hit_any = hit_strap || hit_expctl || hit_event || hit_diag;

  // Per-register strobes, all qualified by the edge where pready is seen high
  wire expctl_write_w = wr_w && hit_expctl;
  wire event_write_w = wr_w && hit_event;
  wire event_read_w = rd_w && hit_event;
  wire diag_write_w = wr_w && hit_diag;
  wire start_req_w = diag_write_w && pwdata[`PVSIR_DIAG_START_BIT];

  // First access cycle: the answer is prepared here, shown in the next
  wire answer_w = psel && penable && !pready;

  reg [15:0] expctl_reg;
  reg [NUM_EVENTS-1:0] enable_reg;
  reg [NUM_EVENTS-1:0] flag_reg;
  reg diag_busy_reg;
  reg [1:0] diag_res_reg;
  reg diag_short_reg;
  reg [2:0] diag_rsv_reg;
  reg [DIST_W-1:0] diag_dist_reg;

  // Expanded control; all bits writable, reserved ones keep what is written
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      expctl_reg <= `PVSIR_EXPCTL_RESET;
    else if (expctl_write_w)
      expctl_reg <= pwdata[15:0];
  end

  // Enables are plain storage; they gate the interrupt, never the flags
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      enable_reg <= {NUM_EVENTS{1'b0}};
    else if (event_write_w)
      enable_reg <= pwdata[`PVSIR_EVENT_EN_LO +: NUM_EVENTS];
  end

  // Per-flag set/clear; a new event in the reading cycle survives the clear,
  // but an event in the cycle where the answer is prepared is cleared unseen
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi = gi + 1) begin : g_flag
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
          flag_reg[gi] <= 1'b0;
        else if (event_pulse[gi])
          flag_reg[gi] <= 1'b1;
        else if (event_read_w)
          flag_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // Busy: set by a start write, cleared only by the engine's done pulse.
  // A start write landing with done while busy is dropped; software sees zero and retries.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      diag_busy_reg <= 1'b0;
    else if (diag_busy_reg && diag_done)
      diag_busy_reg <= 1'b0;
    else if (start_req_w)
      diag_busy_reg <= 1'b1;
  end

  // Results captured at completion only; they hold until the next test ends
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      diag_res_reg <= `PVSIR_DIAG_RES_NORMAL;
      diag_short_reg <= 1'b0;
      diag_dist_reg <= {DIST_W{1'b0}};
    end else if (diag_busy_reg && diag_done) begin
      diag_res_reg <= diag_result;
      diag_short_reg <= diag_short_cable;
      diag_dist_reg <= diag_distance;
    end
  end

  // Reserved bits are stored but steer nothing
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      diag_rsv_reg <= 3'h0;
    else if (diag_write_w)
      diag_rsv_reg <= pwdata[`PVSIR_DIAG_RSV_HI:`PVSIR_DIAG_RSV_LO];
  end

  // Read words per register; strap reserved bits read zero, diag reserved bits read what was written
  wire [15:0] strap_word;
  wire [15:0] event_word;
  wire [15:0] diag_word;
  assign strap_word = {station_reg, 11'h000, rmii_reg, 1'b0};
  assign event_word = {enable_reg, flag_reg};
  assign diag_word = {diag_busy_reg, diag_res_reg, diag_short_reg, diag_rsv_reg,
                      diag_dist_reg};

  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (hit_strap) begin
      rd_mux = strap_word;
    end else if (hit_expctl) begin
      rd_mux = expctl_reg;
    end else if (hit_event) begin
      rd_mux = event_word;
    end else if (hit_diag) begin
      rd_mux = diag_word;
    end
  end

  // One wait state: pready is low in the first access cycle, high with the answer in the next.
  // Registering the answer costs a cycle but keeps prdata off the decode path.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= answer_w;
      if (answer_w) begin
        prdata <= pwrite ? 32'h00000000 : {16'h0000, rd_mux};
        pslverr <= !hit_any;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Interrupt follows the flags one cycle late, so it drops one cycle after a read
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(flag_reg & enable_reg);
  end

  // Start level to the engine lags the register bit by one cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      diag_start <= 1'b0;
    else
      diag_start <= diag_busy_reg;
  end

  // Output is the enable sense, the inverse of the stored disable bit
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      energy_detect_powerdown <= 1'b0;
    else
      energy_detect_powerdown <= !expctl_reg[`PVSIR_EXPCTL_ENERGY_DETECT_POWERDOWN_BIT];
  end

endmodule // pvsir_regs

`default_nettype wire

// *** common/pvsir_defines.vh ***
// Register offsets, field positions and reset values for the PHY vendor register slice.
// Included by the register bank; definitions only.
`ifndef PVSIR_DEFINES_VH
`define PVSIR_DEFINES_VH

// Printed offsets are register indices; byte address is index times four
`define PVSIR_IDX_STRAP 8'h17
`define PVSIR_IDX_EXPCTL 8'h18
`define PVSIR_IDX_EVENT 8'h1b
`define PVSIR_IDX_DIAG 8'h1d

`define PVSIR_ADDR_STRAP 12'h05c
`define PVSIR_ADDR_EXPCTL 12'h060
`define PVSIR_ADDR_EVENT 12'h06c
`define PVSIR_ADDR_DIAG 12'h074

`define PVSIR_STRAP_ADDR_HI 15
`define PVSIR_STRAP_ADDR_LO 13
`define PVSIR_STRAP_RMII_BIT 1
`define PVSIR_STRAP_ADDR_ZERO 3'h0
`define PVSIR_STRAP_ADDR_THREE 3'h3
`define PVSIR_STRAP_WAIT 2'h3

`define PVSIR_EXPCTL_ENERGY_DETECT_POWERDOWN_BIT 11
`define PVSIR_EXPCTL_RESET 16'h0800

`define PVSIR_EVENT_EN_LO 8
`define PVSIR_EVENT_RESET 16'h0000

`define PVSIR_DIAG_START_BIT 15
`define PVSIR_DIAG_RES_HI 14
`define PVSIR_DIAG_RES_LO 13
`define PVSIR_DIAG_SHORT_BIT 12
`define PVSIR_DIAG_RSV_HI 11
`define PVSIR_DIAG_RSV_LO 9
`define PVSIR_DIAG_RESET 16'h0000
`define PVSIR_DIAG_RES_NORMAL 2'h0
`define PVSIR_DIAG_RES_OPEN 2'h1
`define PVSIR_DIAG_RES_SHORT 2'h2
`define PVSIR_DIAG_RES_FAIL 2'h3

`endif

// *** testbench/pvsir_regs_properties.sv ***
// Checker for the PHY vendor register slice, bound to pvsir_regs.
// Assumes one wait state on APB and events on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pvsir_props #(parameter NUM_EVENTS = 8) (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire strap_rmii,
  input wire [NUM_EVENTS-1:0] event_pulse,
  input wire diag_done,
  input wire diag_start,
  input wire energy_detect_powerdown,
  input wire irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire rd = pready && !pwrite;
  wire wr = psel && penable && pready && pwrite;
  sequence rd_evt; rd && paddr == 12'h06c; endsequence
  sequence rd_quiet; rd_evt ##0 event_pulse == 0; endsequence
  chk_strap_addr: assert property (rd && paddr == 12'h05c |-> prdata[15:13] inside {0, 3})
    else $error("strap address out of range");
  chk_strap_mode: assert property (rd && paddr == 12'h05c |-> prdata[1] == strap_rmii)
    else $error("strap mode bit wrong");
  chk_energy_detect_powerdown_out: assert property (wr && paddr == 12'h060 |-> ##2 energy_detect_powerdown == !$past(pwdata[11], 2))
    else $error("powerdown output wrong");
  chk_irq_seen: assert property (rd_evt |-> !(|(prdata[15:8] & prdata[7:0])) || irq)
    else $error("irq low with enabled flag");
  chk_irq_drop: assert property (rd_quiet ##1 event_pulse == 0 |=> !irq)
    else $error("irq stuck after clear");
  chk_start_go: assert property (wr && paddr == 12'h074 && pwdata[15] && !diag_done |-> ##[1:2] diag_start)
    else $error("diagnostic did not start");
  chk_start_hold: assert property (diag_start && !diag_done && !$past(diag_done) |=> diag_start)
    else $error("start dropped early");
  chk_start_end: assert property (diag_start && diag_done |-> ##2 !diag_start)
    else $error("start not cleared");
endmodule // pvsir_props
bind pvsir_regs pvsir_props #(.NUM_EVENTS(NUM_EVENTS)) u_props (.clk_sys, .resetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .strap_rmii, .event_pulse, .diag_done, .diag_start,
  .energy_detect_powerdown, .irq);
`default_nettype wire

// *** testbench/test_phy_vendor_status_irq_regs.sv ***
// Self-checking bench for the PHY vendor register slice over APB.
// Assumes straps held steady from each reset to the next.
`timescale 1ns/1ps
`default_nettype none
module test_phy_vendor_status_irq_regs;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, strap_rmii = 1;
  logic diag_done = 0, diag_short_cable = 0, pready, pslverr, diag_start, irq, err;
  logic energy_detect_powerdown;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [2:0] strap_station_address = 3'h3;
  logic [7:0] event_pulse = 0;
  logic [1:0] diag_result = 0;
  logic [8:0] diag_distance = 0;
  logic [15:0] rv;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  pvsir_regs dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .strap_station_address, .strap_rmii, .event_pulse, .diag_done,
    .diag_result, .diag_short_cable, .diag_distance, .diag_start, .energy_detect_powerdown, .irq);
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata[15:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task ev(input logic [7:0] v);
    @(posedge clk_sys);
    event_pulse <= v;
    @(posedge clk_sys);
    event_pulse <= 0;
    repeat (3) @(posedge clk_sys);
  endtask
  task stop_test;
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1;
    repeat (6) @(posedge clk_sys);
    apb(0, 12'h05c, 0);
    chk("strap", rv, 16'h6002);
    apb(0, 12'h060, 0);
    chk("expctl", rv, 16'h0800);
    chk("energy_detect_powerdown", {15'h0, energy_detect_powerdown}, 0);
    apb(1, 12'h060, 0);
    repeat (2) @(posedge clk_sys);
    chk("energy_detect_powerdown", {15'h0, energy_detect_powerdown}, 1);
    apb(0, 12'h06c, 0);
    chk("event", rv, 0);
    apb(0, 12'h074, 0);
    chk("diag", rv, 0);
    apb(0, 12'h000, 0);
    chk("slverr", {15'h0, err}, 1);
    apb(1, 12'h06c, 16'h8100);
    ev(8'h81);
    chk("irq", {15'h0, irq}, 1);
    apb(0, 12'h06c, 0);
    chk("flags", rv, 16'h8181);
    apb(0, 12'h06c, 0);
    chk("cleared", rv, 16'h8100);
    chk("irq", {15'h0, irq}, 0);
    ev(8'h02);
    chk("masked", {15'h0, irq}, 0);
    apb(0, 12'h06c, 0);
    chk("flags", rv, 16'h8102);
    for (int r = 0; r < 4; r++) begin
      apb(1, 12'h074, 16'h8e00);
      repeat (2) @(posedge clk_sys);
      chk("start_out", {15'h0, diag_start}, 1);
      apb(0, 12'h074, 0);
      chk("running", {15'h0, rv[15]}, 1);
      diag_result <= r[1:0];
      diag_short_cable <= r[0];
      diag_distance <= 9'h1f0 | r[8:0];
      diag_done <= 1;
      @(posedge clk_sys);
      diag_done <= 0;
      repeat (3) @(posedge clk_sys);
      chk("start_end", {15'h0, diag_start}, 0);
      apb(0, 12'h074, 0);
      chk("result", rv, {1'b0, r[1:0], r[0], 3'h7, 9'h1f0 | r[8:0]});
    end
    // Second reset: unsupported strap address, reduced mode not strapped
    strap_station_address <= 3'h5;
    strap_rmii <= 0;
    resetn <= 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1;
    repeat (6) @(posedge clk_sys);
    chk("energy_detect_powerdown_rst", {15'h0, energy_detect_powerdown}, 0);
    apb(0, 12'h05c, 0);
    chk("strap_bad", rv, 16'h0000);
    apb(0, 12'h060, 0);
    chk("expctl_rst", rv, 16'h0800);
    apb(0, 12'h06c, 0);
    chk("event_rst", rv, 0);
    apb(0, 12'h074, 0);
    chk("diag_rst", rv, 0);
    stop_test;
  end
endmodule // test_phy_vendor_status_irq_regs
`default_nettype wire
